// file: hw/fieldbus_request_watchdog.sv
// Purpose: fieldbus failure watchdog on Modbus request traffic
// Assumes: request decoder hands over one pulse per request with its function code
// Notes: register port is the Modbus register access path, one word per cycle
`timescale 1ns/10ps

// What this block does
// - while running, an enabled-function-code request reloads the countdown unless it coincides with the expiring tick
// - after expiry every later request answers with exception 0x0004
// - after power-up the watchdog stays inactive until armed
// - minimum remaining time at 0x1004 reads zero after a fault
// - writing 0x1 to 0x1007 reloads the countdown only while running
// - running watchdog stops via sequenced stop 0x1005 or simple stop 0x1008
// - timeout setting is unsigned 16 bits, reset 0x0000
// - writing the timeout only stores, never starts or reloads
// - trigger cannot start the watchdog while timeout is zero
// - timeout counts in 100 ms units
// - while running, timeout and both mask writes are rejected
// - low mask bit n-1 enables function code n
// - all low mask bits set enable codes 1 to 16
// - registers reached by ordinary Modbus read and write with register address
// - minimum remaining time resets 0xffff, tracks smaller remaining count
// - sequenced stop needs 0xaaaa then 0x5555
// - status reads 0 inactive, 1 active, 2 expired
module fieldbus_request_watchdog #(
   parameter int TICK_CYCLES = fbwd_pkg::TICK_CYCLES
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // register access
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [15:0] reg_addr_i,
   input wire logic [15:0] reg_wdata_i,
   output logic [15:0] reg_rdata_o,
   output logic reg_rvalid_o,
   output logic reg_hit_o,
   // request stream
   input wire logic req_valid_i,
   input wire logic [7:0] req_func_i,
   output logic req_fail_o,
   output logic [7:0] req_exc_code_o,
   // status
   output logic running_o,
   output logic expired_o
);
   typedef enum {ST_IDLE, ST_RUN, ST_EXPIRED} wd_state_e;

   // ==========================================
   // state
   wd_state_e state, next_state;
   logic [15:0] timeout, next_timeout;
   logic [15:0] mask_low, next_mask_low;
   logic [15:0] mask_high, next_mask_high;
   logic [15:0] kick, next_kick;
   logic [15:0] min_remain, next_min_remain;
   logic [15:0] seq_stop, next_seq_stop;
   logic [15:0] restart, next_restart;
   logic [15:0] simple_stop, next_simple_stop;
   logic [15:0] remain, next_remain;
   logic [31:0] tick_cnt, next_tick_cnt;
   logic [15:0] next_rdata;
   logic next_rvalid;
   logic next_hit;
   logic next_fail;
   logic tick;
   logic enabled_req;
   logic [4:0] fidx;

   always_comb begin
      tick = (tick_cnt == 32'(TICK_CYCLES - 1));
      fidx = 5'(req_func_i - 8'h01);
      enabled_req = 1'b0;
      if (req_valid_i && req_func_i >= 8'h01 && req_func_i <= 8'h10) begin
         enabled_req = mask_low[fidx[3:0]];
      end else if (req_valid_i && req_func_i >= 8'h11 && req_func_i <= 8'h20) begin
         enabled_req = mask_high[fidx[3:0]];
      end
   end

   // ==========================================
   // next state
   always_comb begin
      next_state = state;
      next_timeout = timeout;
      next_mask_low = mask_low;
      next_mask_high = mask_high;
      next_kick = kick;
      next_min_remain = min_remain;
      next_seq_stop = seq_stop;
      next_restart = restart;
      next_simple_stop = simple_stop;
      next_remain = remain;
      next_tick_cnt = (state == ST_RUN && !tick) ? tick_cnt + 32'h1 : 32'h0;
      next_fail = req_valid_i && state == ST_EXPIRED;
      next_rvalid = reg_rd_i;
      next_hit = 1'b0;
      next_rdata = 16'h0000;
      // countdown
      if (state == ST_RUN) begin
         if (tick) begin
            next_remain = remain - 16'h1;
            if (remain == 16'h1) begin
               next_state = ST_EXPIRED;
            end
         end
         if (next_remain < min_remain) begin
            next_min_remain = next_remain;
         end
         if (enabled_req && next_state == ST_RUN) begin
            next_remain = timeout;
            next_tick_cnt = 32'h0;
         end
      end
      // register writes
      if (reg_wr_i) begin
         unique case (reg_addr_i)
            fbwd_pkg::OFS_TIMEOUT: begin
               if (state != ST_RUN) next_timeout = reg_wdata_i;
            end
            fbwd_pkg::OFS_MASK_LOW: begin
               if (state != ST_RUN) next_mask_low = reg_wdata_i;
            end
            fbwd_pkg::OFS_MASK_HIGH: begin
               if (state != ST_RUN) next_mask_high = reg_wdata_i;
            end
            fbwd_pkg::OFS_KICK: begin
               next_kick = reg_wdata_i;
               if (reg_wdata_i != 16'h0000 && reg_wdata_i != kick && timeout != 16'h0000
                   && state != ST_EXPIRED) begin
                  next_state = ST_RUN;
                  next_remain = timeout;
                  next_tick_cnt = 32'h0;
               end
            end
            fbwd_pkg::OFS_SEQ_STOP: begin
               next_seq_stop = reg_wdata_i;
               if (state == ST_RUN && seq_stop == fbwd_pkg::STOP_FIRST &&
                   reg_wdata_i == fbwd_pkg::STOP_SECOND) begin
                  next_state = ST_IDLE;
               end
            end
            fbwd_pkg::OFS_RESTART: begin
               next_restart = reg_wdata_i;
               if (reg_wdata_i == fbwd_pkg::RESTART_CODE && state == ST_RUN) begin
                  next_remain = timeout;
                  next_tick_cnt = 32'h0;
                  next_state = ST_RUN;
               end
            end
            fbwd_pkg::OFS_SIMPLE_STOP: begin
               next_simple_stop = reg_wdata_i;
               if (state == ST_RUN && (reg_wdata_i == fbwd_pkg::SIMPLE_STOP_A ||
                   reg_wdata_i == fbwd_pkg::SIMPLE_STOP_B)) begin
                  next_state = ST_IDLE;
               end
            end
            default: begin
            end
         endcase
      end
      // register reads
      if (reg_rd_i) begin
         next_hit = 1'b1;
         unique case (reg_addr_i)
            fbwd_pkg::OFS_TIMEOUT: next_rdata = timeout;
            fbwd_pkg::OFS_MASK_LOW: next_rdata = mask_low;
            fbwd_pkg::OFS_MASK_HIGH: next_rdata = mask_high;
            fbwd_pkg::OFS_KICK: next_rdata = kick;
            fbwd_pkg::OFS_MIN_REMAIN: next_rdata = min_remain;
            fbwd_pkg::OFS_SEQ_STOP: next_rdata = seq_stop;
            fbwd_pkg::OFS_STATE: begin
               unique case (state)
                  ST_IDLE: next_rdata = fbwd_pkg::STATE_INACTIVE;
                  ST_RUN: next_rdata = fbwd_pkg::STATE_ACTIVE;
                  ST_EXPIRED: next_rdata = fbwd_pkg::STATE_EXPIRED;
               endcase
            end
            fbwd_pkg::OFS_RESTART: next_rdata = restart;
            fbwd_pkg::OFS_SIMPLE_STOP: next_rdata = simple_stop;
            default: next_hit = 1'b0;
         endcase
      end
   end

   // ==========================================
   // registers
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state <= ST_IDLE;
         timeout <= fbwd_pkg::RST_TIMEOUT;
         mask_low <= fbwd_pkg::RST_MASK;
         mask_high <= fbwd_pkg::RST_MASK;
         kick <= fbwd_pkg::RST_KICK;
         min_remain <= fbwd_pkg::RST_MIN_REMAIN;
         seq_stop <= fbwd_pkg::RST_SEQ_STOP;
         restart <= fbwd_pkg::RST_RESTART;
         simple_stop <= fbwd_pkg::RST_SIMPLE_STOP;
         remain <= 16'h0000;
         tick_cnt <= 32'h0;
         reg_rdata_o <= 16'h0000;
         reg_rvalid_o <= 1'b0;
         reg_hit_o <= 1'b0;
         req_fail_o <= 1'b0;
      end else begin
         state <= next_state;
         timeout <= next_timeout;
         mask_low <= next_mask_low;
         mask_high <= next_mask_high;
         kick <= next_kick;
         min_remain <= next_min_remain;
         seq_stop <= next_seq_stop;
         restart <= next_restart;
         simple_stop <= next_simple_stop;
         remain <= next_remain;
         tick_cnt <= next_tick_cnt;
         reg_rdata_o <= next_rdata;
         reg_rvalid_o <= next_rvalid;
         reg_hit_o <= next_hit;
         req_fail_o <= next_fail;
      end
   end

   assign req_exc_code_o = req_fail_o ? fbwd_pkg::EXC_DEVICE_FAILURE : 8'h00;
   assign running_o = (state == ST_RUN);
   assign expired_o = (state == ST_EXPIRED);

   // ==========================================
   // checks
   a_expire_fail: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (state == ST_EXPIRED && req_valid_i) |=> (req_fail_o && req_exc_code_o == 8'h04))
      else $error("request after expiry not failed");
   a_fault_min_zero: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      $rose(state == ST_EXPIRED) |-> (min_remain == 16'h0000))
      else $error("min remaining not zero at expiry");
   a_zero_no_arm: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (state == ST_IDLE && timeout == 16'h0000) |=> (state != ST_RUN))
      else $error("armed with zero timeout");
   a_run_locks_cfg: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (state == ST_RUN && reg_wr_i && reg_addr_i == fbwd_pkg::OFS_TIMEOUT) |=> $stable(timeout))
      else $error("timeout changed while running");
   a_mask_lock: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (state == ST_RUN) |=> (state != ST_RUN || $stable(mask_low)))
      else $error("mask changed while running");
   a_req_reload: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (state == ST_RUN && enabled_req && !tick && !reg_wr_i) |=> (remain == timeout))
      else $error("enabled request did not reload");
   a_timeout_store: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (state == ST_IDLE && reg_wr_i && reg_addr_i == fbwd_pkg::OFS_TIMEOUT) |=> (state == ST_IDLE))
      else $error("timeout write started watchdog");
   a_min_track: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (state == ST_RUN && $past(state) == ST_RUN) |-> (min_remain <= remain))
      else $error("min remaining above remaining");
   a_seq_stop: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (state == ST_RUN && reg_wr_i && reg_addr_i == fbwd_pkg::OFS_SEQ_STOP &&
       reg_wdata_i == fbwd_pkg::STOP_SECOND && seq_stop != fbwd_pkg::STOP_FIRST) |=> (state != ST_IDLE))
      else $error("stop without first key");
   a_status_read: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (reg_rd_i && reg_addr_i == fbwd_pkg::OFS_STATE && state == ST_EXPIRED) |=> (reg_rdata_o == 16'h0002))
      else $error("status read wrong");
endmodule

// file: hw/fbwd_pkg.sv
// Purpose: constants for the fieldbus request watchdog
// Assumes: 16-bit register words, 200 MHz system clock
// Notes: offsets are register numbers used as reference numbers
package fbwd_pkg;
   // ==========================================
   // register offsets
   localparam logic [15:0] OFS_TIMEOUT = 16'h1000;
   localparam logic [15:0] OFS_MASK_LOW = 16'h1001;
   localparam logic [15:0] OFS_MASK_HIGH = 16'h1002;
   localparam logic [15:0] OFS_KICK = 16'h1003;
   localparam logic [15:0] OFS_MIN_REMAIN = 16'h1004;
   localparam logic [15:0] OFS_SEQ_STOP = 16'h1005;
   localparam logic [15:0] OFS_STATE = 16'h1006;
   localparam logic [15:0] OFS_RESTART = 16'h1007;
   localparam logic [15:0] OFS_SIMPLE_STOP = 16'h1008;
   // ==========================================
   // reset values and codes
   localparam logic [15:0] RST_TIMEOUT = 16'h0000;
   localparam logic [15:0] RST_MASK = 16'h0000;
   localparam logic [15:0] RST_KICK = 16'h0000;
   localparam logic [15:0] RST_MIN_REMAIN = 16'hffff;
   localparam logic [15:0] RST_SEQ_STOP = 16'h0000;
   localparam logic [15:0] RST_RESTART = 16'h0001;
   localparam logic [15:0] RST_SIMPLE_STOP = 16'h0000;
   localparam logic [15:0] STATE_INACTIVE = 16'h0000;
   localparam logic [15:0] STATE_ACTIVE = 16'h0001;
   localparam logic [15:0] STATE_EXPIRED = 16'h0002;
   localparam logic [15:0] STOP_FIRST = 16'haaaa;
   localparam logic [15:0] STOP_SECOND = 16'h5555;
   localparam logic [15:0] SIMPLE_STOP_A = 16'h55aa;
   localparam logic [15:0] SIMPLE_STOP_B = 16'haa55;
   localparam logic [15:0] RESTART_CODE = 16'h0001;
   localparam logic [7:0] EXC_DEVICE_FAILURE = 8'h04;
   // ==========================================
   // timing
   localparam int CLK_HZ = 200_000_000;
   localparam int TICK_MS = 100;
   localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
endpackage

// file: verif/fbwd_master.sv
// Purpose: fieldbus master model for register and request traffic
// Assumes: inputs change 1 ns after the rising edge
// Notes: released lines show the inverse of their last value
`timescale 1ns/10ps
module fbwd_master (
   // clock
   input wire logic sys_clk_i,
   // register access
   output logic reg_wr_o,
   output logic reg_rd_o,
   output logic [15:0] reg_addr_o,
   output logic [15:0] reg_wdata_o,
   input wire logic [15:0] reg_rdata_i,
   input wire logic reg_rvalid_i,
   input wire logic reg_hit_i,
   // request stream
   output logic req_valid_o,
   output logic [7:0] req_func_o,
   input wire logic req_fail_i,
   input wire logic [7:0] req_exc_code_i
);
   initial begin
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
      reg_addr_o = 16'h0000;
      reg_wdata_o = 16'h0000;
      req_valid_o = 1'b0;
      req_func_o = 8'h00;
   end
   // ==========================================
   // one word write by register number
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge sys_clk_i);
      #1;
      reg_wr_o = 1'b1;
      reg_addr_o = a;
      reg_wdata_o = d;
      @(posedge sys_clk_i);
      #1;
      reg_wr_o = 1'b0;
      reg_addr_o = ~a;
      reg_wdata_o = ~d;
   endtask
   // ==========================================
   // one word read, data unknown without rvalid
   task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic h);
      @(posedge sys_clk_i);
      #1;
      reg_rd_o = 1'b1;
      reg_addr_o = a;
      @(posedge sys_clk_i);
      #1;
      reg_rd_o = 1'b0;
      reg_addr_o = ~a;
      d = reg_rvalid_i ? reg_rdata_i : 16'hxxxx;
      h = reg_hit_i;
   endtask
   // ==========================================
   // one request with its function code
   task automatic req(input logic [7:0] f, output logic fail, output logic [7:0] exc);
      @(posedge sys_clk_i);
      #1;
      req_valid_o = 1'b1;
      req_func_o = f;
      @(posedge sys_clk_i);
      #1;
      req_valid_o = 1'b0;
      req_func_o = ~f;
      fail = req_fail_i;
      exc = req_exc_code_i;
   endtask
endmodule

// file: verif/tb_fieldbus_request_watchdog.sv
// Purpose: self-checking bench for the fieldbus request watchdog
// Assumes: tick shortened to 4 cycles, timeout 5 ticks
// Notes: master model drives every input but clock and reset
`timescale 1ns/10ps
module tb_fieldbus_request_watchdog;
   logic sys_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wr, rd, rv, hit, rqv, fail, running, expired;
   logic [15:0] addr, wdata, rdata;
   logic [7:0] func, exc;
   int n_mismatch = 0;
   int n_checks = 0;
   localparam int TICK = 4;
   always #2.5 sys_clk_i = ~sys_clk_i;
   // ==========================================
   // design and master
   fieldbus_request_watchdog #(.TICK_CYCLES(TICK)) DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_wr_i(wr),
      .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rv),
      .reg_hit_o(hit), .req_valid_i(rqv), .req_func_i(func), .req_fail_o(fail), .req_exc_code_o(exc),
      .running_o(running), .expired_o(expired));
   fbwd_master m (.sys_clk_i(sys_clk_i), .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(addr),
      .reg_wdata_o(wdata), .reg_rdata_i(rdata), .reg_rvalid_i(rv), .reg_hit_i(hit), .req_valid_o(rqv),
      .req_func_o(func), .req_fail_i(fail), .req_exc_code_i(exc));
   // ==========================================
   // checking helpers
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rdchk(input logic [15:0] a, input logic [15:0] exp);
      logic [15:0] d;
      logic h;
      m.rd(a, d, h);
      chk(d, exp);
      chk({15'h0000, h}, {15'h0000, a >= fbwd_pkg::OFS_TIMEOUT && a <= fbwd_pkg::OFS_SIMPLE_STOP});
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // keep alive by request code f, or by restart when f is zero
   task automatic alive(input logic [7:0] f);
      logic fl;
      logic [7:0] ex;
      for (int i = 0; i < 8; i++) begin
         if (f == 8'h00) m.wr(fbwd_pkg::OFS_RESTART, fbwd_pkg::RESTART_CODE);
         else begin
            m.req(f, fl, ex);
            chk({7'h00, fl, ex}, 16'h0000);
         end
         repeat (3) @(posedge sys_clk_i);
      end
      #1;
      chk({running, expired}, 16'h0002);
   endtask
   // ==========================================
   // scenarios
   task automatic t_reset();
      chk({running, expired}, 16'h0000);
      rdchk(fbwd_pkg::OFS_TIMEOUT, 16'h0000);
      rdchk(fbwd_pkg::OFS_MASK_LOW, 16'h0000);
      rdchk(fbwd_pkg::OFS_MASK_HIGH, 16'h0000);
      rdchk(fbwd_pkg::OFS_MIN_REMAIN, 16'hffff);
      rdchk(fbwd_pkg::OFS_STATE, 16'h0000);
      rdchk(fbwd_pkg::OFS_RESTART, 16'h0001);
      rdchk(16'h1009, 16'h0000);
      chk({15'h0000, hit}, 16'h0000);
      $display("test reset done");
   endtask
   task automatic t_arm();
      m.wr(fbwd_pkg::OFS_KICK, 16'h0001);
      rdchk(fbwd_pkg::OFS_STATE, 16'h0000);
      m.wr(fbwd_pkg::OFS_TIMEOUT, 16'h0005);
      rdchk(fbwd_pkg::OFS_STATE, 16'h0000);
      m.wr(fbwd_pkg::OFS_MASK_LOW, 16'h0008);
      m.wr(fbwd_pkg::OFS_KICK, 16'h0002);
      rdchk(fbwd_pkg::OFS_STATE, 16'h0001);
      m.wr(fbwd_pkg::OFS_TIMEOUT, 16'h0007);
      rdchk(fbwd_pkg::OFS_TIMEOUT, 16'h0005);
      m.wr(fbwd_pkg::OFS_MASK_LOW, 16'hffff);
      rdchk(fbwd_pkg::OFS_MASK_LOW, 16'h0008);
      alive(8'h04);
      alive(8'h00);
      $display("test arm done");
   endtask
   task automatic t_stop();
      m.wr(fbwd_pkg::OFS_SEQ_STOP, 16'h5555);
      rdchk(fbwd_pkg::OFS_STATE, 16'h0001);
      m.wr(fbwd_pkg::OFS_SEQ_STOP, 16'haaaa);
      m.wr(fbwd_pkg::OFS_SEQ_STOP, 16'h5555);
      rdchk(fbwd_pkg::OFS_STATE, 16'h0000);
      m.wr(fbwd_pkg::OFS_MASK_LOW, 16'hffff);
      m.wr(fbwd_pkg::OFS_KICK, 16'h0003);
      alive(8'h10);
      m.wr(fbwd_pkg::OFS_SIMPLE_STOP, 16'h55aa);
      rdchk(fbwd_pkg::OFS_STATE, 16'h0000);
      m.wr(fbwd_pkg::OFS_KICK, 16'h0005);
      rdchk(fbwd_pkg::OFS_STATE, 16'h0001);
      m.wr(fbwd_pkg::OFS_SIMPLE_STOP, 16'haa55);
      rdchk(fbwd_pkg::OFS_STATE, 16'h0000);
      $display("test stop done");
   endtask
   task automatic t_expire();
      int n;
      logic fl;
      logic [7:0] ex;
      m.wr(fbwd_pkg::OFS_KICK, 16'h0004);
      n = 0;
      while (expired !== 1'b1 && n < 100) begin
         @(posedge sys_clk_i);
         #1;
         n++;
      end
      chk(16'(n), 16'(5 * TICK));
      chk({running, expired}, 16'h0001);
      rdchk(fbwd_pkg::OFS_STATE, 16'h0002);
      rdchk(fbwd_pkg::OFS_MIN_REMAIN, 16'h0000);
      m.req(8'h03, fl, ex);
      chk({7'h00, fl, ex}, 16'h0104);
      m.wr(fbwd_pkg::OFS_RESTART, fbwd_pkg::RESTART_CODE);
      #1;
      chk({running, expired}, 16'h0001);
      $display("test expire done");
   endtask
   initial begin
      repeat (5) @(posedge sys_clk_i);
      #1;
      rst_i = 1'b0;
      t_reset();
      t_arm();
      t_stop();
      t_expire();
      summarize();
   end
endmodule
